// *** src/ssr_pkg.sv ***
// package of the synchronous serial slave receiver: register map,
// field positions, reset values and shared types.
// assumes a 32-bit axi4-lite slave with 8 address bits.
package ssr_pkg;

    ////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFF_RECEIVE_STATUS_CONTROL_1 = 8'h00;
    localparam logic [7:0] OFF_TRANSMIT_STATUS_CONTROL_1 = 8'h04;
    localparam logic [7:0] OFF_BAUD_CONTROL_1 = 8'h08;
    localparam logic [7:0] OFF_BAUD_DIVISOR_LOW_1 = 8'h0c;
    localparam logic [7:0] OFF_BAUD_DIVISOR_HIGH_1 = 8'h10;
    localparam logic [7:0] OFF_RECEIVE_HOLDING_1 = 8'h14;
    localparam logic [7:0] OFF_INT_STATUS = 8'h18;
    localparam logic [7:0] OFF_INT_MASK = 8'h1c;

    ////////////////////////////////////////////////////////////////////
    // receive status and control fields
    localparam int RC_SERIAL_PORT_ENABLE = 7;
    localparam int RC_NINTH_BIT_RECEIVE_ENABLE = 6;
    localparam int RC_SINGLE_RECEIVE_ENABLE = 5;
    localparam int RC_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int RC_FRAMING_ERROR = 2;
    localparam int RC_OVERRUN_ERROR = 1;
    localparam int RC_RECEIVED_NINTH_BIT = 0;
    // transmit status and control fields
    localparam int TX_CLOCK_SOURCE_SELECT = 7;
    localparam int TX_SYNC_SELECT = 4;
    localparam int TX_SHIFT_EMPTY = 1;
    // baud control fields
    localparam int BD_RECEIVE_IDLE = 6;
    localparam int BD_DATA_INVERT = 5;
    localparam int BD_CLOCK_INVERT = 4;
    // interrupt status and mask fields
    localparam int IS_WORD_DONE = 0;
    localparam int IS_OVERRUN = 1;
    localparam int IS_DATA_AVAIL = 2;

    ////////////////////////////////////////////////////////////////////
    // reset values and writable masks
    localparam logic [7:0] RST_RECEIVE_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] RST_BAUD_CONTROL = 8'h00;
    localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;
    localparam logic [1:0] RST_INT_MASK = 2'h0;
    localparam logic [7:0] WM_RECEIVE_STATUS_CONTROL = 8'hf8;
    localparam logic [7:0] WM_TRANSMIT_STATUS_CONTROL = 8'hfd;
    localparam logic [7:0] WM_BAUD_CONTROL = 8'h3b;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int RX_FIFO_DEPTH = 2;

    // one received word: eight data bits and the optional ninth
    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } ssr_word_s;

endpackage

// *** src/ssr_rx_fifo.sv ***
// receive holding fifo of the serial slave receiver.
// assumes one clock, synchronous active-low reset, flush from the owner.
`timescale 1ns/10ps
`default_nettype none
module ssr_rx_fifo import ssr_pkg::*; #(
    parameter int DEPTH = RX_FIFO_DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire ssr_word_s in_word,
    output logic out_valid,
    input wire logic out_ready,
    output ssr_word_s out_word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        ssr_word_s [DEPTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] cnt;
    } ssr_fifo_s;

    ssr_fifo_s s_q;
    ssr_fifo_s s_d;
    logic push;
    logic pop;

    // refuse a depth the pointers cannot serve
    if (DEPTH < 1) begin : g_chk
        $error("ssr_rx_fifo: DEPTH must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////
    // handshakes and head word straight from the flops
    assign in_ready = (s_q.cnt != CW'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_word = s_q.mem[s_q.rd];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // next state: write at wr, read at rd, count tracks both
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_word;
            s_d.wr = (s_q.wr == PW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == PW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
        if (flush) begin
            s_d.wr = '0;
            s_d.rd = '0;
            s_d.cnt = '0;
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// *** src/ssr_receiver.sv ***
// synchronous slave receive path with an axi4-lite register file.
// assumes the external master drives clock and data pins; pins are
// synchronised here; one core clock aclk, synchronous active-low reset.
//
// Summary of operation
// - slave receive works like master receive otherwise
// - continuous receive never idles while enabled
// - single receive enable is ignored
// - word completes while device sleeps
// - finished word moves into holding fifo
// - enabled completion during sleep raises wake
// - ninth bit enable gives 9-bit words
// - continuous receive enable starts reception
// - completion sets flag and maybe interrupt
// - ninth bit shown in status register
// - low eight bits read from holding fifo
// - overrun held until enable cleared; disable resets
// - unimplemented bits read zero
// - baud divisor bytes stored, unused here
// - port enable on, clock from pin
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module ssr_receiver import ssr_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe_n,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe_n,
    input wire logic sleep_mode,
    output logic wake_request,
    output logic irq
);
    typedef struct packed {
        logic ck_s1;
        logic ck_s2;
        logic ck_s3;
        logic dt_s1;
        logic dt_s2;
        logic [8:0] receive_shift_register;
        logic [3:0] cnt;
        logic overrun_error;
        logic [7:0] rcv_ctl;
        logic [7:0] xmt_ctl;
        logic [7:0] baud_ctl;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [1:0] int_stat;
        logic [1:0] int_mask;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } ssr_state_s;

    ssr_state_s s_q;
    ssr_state_s s_d;
    logic wr_go;
    logic rd_go;
    logic active;
    logic rx_on;
    logic clk_edge;
    logic bit_in;
    logic [3:0] last_bit;
    logic [8:0] shifted;
    logic done;
    ssr_word_s new_word;
    logic fifo_in_ready;
    logic fifo_valid;
    logic fifo_pop;
    ssr_word_s head;
    logic [7:0] wr_off;
    logic [7:0] rd_off;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic wr_hit;

    if (ADDR_W < 8 || ADDR_W > 32 || FIFO_DEPTH < 1) begin : g_chk
        $error("ssr_receiver: ADDR_W must be 8..32, FIFO_DEPTH >= 1");
    end

    ////////////////////////////////////////////////////////////////////
    // bus handshakes: write needs address and data together
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_q.bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign rd_go = s_axi_arvalid & ~s_q.rvalid;
    assign s_axi_arready = ~s_q.rvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign wr_off = {s_axi_awaddr[7:2], 2'b00};
    assign rd_off = {s_axi_araddr[7:2], 2'b00};

    // the pins are inputs only; drivers stay off
    assign serial_clock_pin_out = 1'b0;
    assign serial_clock_pin_oe_n = 1'b1;
    assign serial_data_pin_out = 1'b0;
    assign serial_data_pin_oe_n = 1'b1;

    ////////////////////////////////////////////////////////////////////
    // mode decode: enabled, synchronous, clock taken from the pin
    assign active = s_q.rcv_ctl[RC_SERIAL_PORT_ENABLE]
        & s_q.xmt_ctl[TX_SYNC_SELECT]
        & ~s_q.xmt_ctl[TX_CLOCK_SOURCE_SELECT];
    // single receive enable plays no part; never idles once on
    assign rx_on = active
        & s_q.rcv_ctl[RC_CONTINUOUS_RECEIVE_ENABLE];

    // sampling edge from synchronised clock, polarity selectable
    assign clk_edge = s_q.baud_ctl[BD_CLOCK_INVERT]
        ? (s_q.ck_s2 & ~s_q.ck_s3)
        : (~s_q.ck_s2 & s_q.ck_s3);
    assign bit_in = s_q.dt_s2 ^ s_q.baud_ctl[BD_DATA_INVERT];
    assign last_bit = s_q.rcv_ctl[RC_NINTH_BIT_RECEIVE_ENABLE]
        ? 4'd8 : 4'd7;
    assign shifted = {bit_in, s_q.receive_shift_register[8:1]};
    // sleep_mode is not looked at: reception goes on asleep
    assign done = rx_on & clk_edge & (s_q.cnt == last_bit);
    // least significant bit arrives first
    always_comb begin
        if (s_q.rcv_ctl[RC_NINTH_BIT_RECEIVE_ENABLE]) begin
            new_word.ninth = shifted[8];
            new_word.data = shifted[7:0];
        end else begin
            new_word.ninth = 1'b0;
            new_word.data = shifted[8:1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // holding fifo; emptied when the port is disabled
    assign fifo_pop = rd_go & (rd_off == OFF_RECEIVE_HOLDING_1);
    ssr_rx_fifo #(
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .flush(~active),
        .in_valid(done),
        .in_ready(fifo_in_ready),
        .in_word(new_word),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_word(head)
    );

    ////////////////////////////////////////////////////////////////////
    // read data mux; upper bits and framing error read zero
    always_comb begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        case (rd_off)
            OFF_RECEIVE_STATUS_CONTROL_1: begin
                rd_byte = s_q.rcv_ctl;
                rd_byte[RC_FRAMING_ERROR] = 1'b0;
                rd_byte[RC_OVERRUN_ERROR] = s_q.overrun_error;
                rd_byte[RC_RECEIVED_NINTH_BIT] = head.ninth;
            end
            OFF_TRANSMIT_STATUS_CONTROL_1: begin
                rd_byte = s_q.xmt_ctl;
                rd_byte[TX_SHIFT_EMPTY] = 1'b1;
            end
            OFF_BAUD_CONTROL_1: begin
                rd_byte = s_q.baud_ctl;
                rd_byte[BD_RECEIVE_IDLE] = ~rx_on;
            end
            OFF_BAUD_DIVISOR_LOW_1: rd_byte = s_q.div_lo;
            OFF_BAUD_DIVISOR_HIGH_1: rd_byte = s_q.div_hi;
            OFF_RECEIVE_HOLDING_1: rd_byte = head.data;
            OFF_INT_STATUS: rd_byte = {5'h00, fifo_valid, s_q.int_stat};
            OFF_INT_MASK: rd_byte = {6'h00, s_q.int_mask};
            default: rd_hit = 1'b0;
        endcase
    end

    // write decode: known offsets answer okay
    always_comb begin
        case (wr_off)
            OFF_RECEIVE_STATUS_CONTROL_1,
            OFF_TRANSMIT_STATUS_CONTROL_1,
            OFF_BAUD_CONTROL_1,
            OFF_BAUD_DIVISOR_LOW_1,
            OFF_BAUD_DIVISOR_HIGH_1,
            OFF_RECEIVE_HOLDING_1,
            OFF_INT_STATUS,
            OFF_INT_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // next state of the whole block
    always_comb begin
        s_d = s_q;
        // two flops per pin before any logic, third for the edge
        s_d.ck_s1 = serial_clock_pin_in;
        s_d.ck_s2 = s_q.ck_s1;
        s_d.ck_s3 = s_q.ck_s2;
        s_d.dt_s1 = serial_data_pin_in;
        s_d.dt_s2 = s_q.dt_s1;
        // shift one bit per sampling edge, as master reception does
        if (rx_on && clk_edge) begin
            s_d.receive_shift_register = shifted;
            s_d.cnt = done ? 4'd0 : s_q.cnt + 4'd1;
        end
        // completion: flag, then store or flag overrun and drop
        if (done) begin
            s_d.int_stat[IS_WORD_DONE] = 1'b1;
            if (!fifo_in_ready) begin
                s_d.overrun_error = 1'b1;
                s_d.int_stat[IS_OVERRUN] = 1'b1;
            end
        end
        // clearing either enable clears overrun; disable resets unit
        if (!rx_on) begin
            s_d.overrun_error = 1'b0;
            s_d.cnt = 4'd0;
            s_d.receive_shift_register = 9'h000;
        end
        // bus write; a hardware set wins over a one-to-clear
        if (wr_go) begin
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_wstrb[0]) begin
                case (wr_off)
                    OFF_RECEIVE_STATUS_CONTROL_1: s_d.rcv_ctl =
                        s_axi_wdata[7:0] & WM_RECEIVE_STATUS_CONTROL;
                    OFF_TRANSMIT_STATUS_CONTROL_1: s_d.xmt_ctl =
                        s_axi_wdata[7:0] & WM_TRANSMIT_STATUS_CONTROL;
                    OFF_BAUD_CONTROL_1: s_d.baud_ctl =
                        s_axi_wdata[7:0] & WM_BAUD_CONTROL;
                    OFF_BAUD_DIVISOR_LOW_1: s_d.div_lo = s_axi_wdata[7:0];
                    OFF_BAUD_DIVISOR_HIGH_1: s_d.div_hi = s_axi_wdata[7:0];
                    OFF_INT_STATUS: s_d.int_stat = s_d.int_stat
                        & ~(s_axi_wdata[1:0] & ~{done & ~fifo_in_ready,
                        done});
                    OFF_INT_MASK: s_d.int_mask = s_axi_wdata[1:0];
                    default: s_d.bvalid = 1'b1;
                endcase
            end
        end else if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // bus read: answer registered one cycle after acceptance
        if (rd_go) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = {24'h000000, rd_byte};
            s_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.rcv_ctl <= RST_RECEIVE_STATUS_CONTROL;
            s_q.xmt_ctl <= RST_TRANSMIT_STATUS_CONTROL;
            s_q.baud_ctl <= RST_BAUD_CONTROL;
            s_q.div_lo <= RST_BAUD_DIVISOR;
            s_q.div_hi <= RST_BAUD_DIVISOR;
            s_q.int_mask <= RST_INT_MASK;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt and wake: unmasked sticky bits, wake only asleep
    assign irq = |(s_q.int_stat & s_q.int_mask);
    assign wake_request = sleep_mode
        & s_q.int_stat[IS_WORD_DONE] & s_q.int_mask[IS_WORD_DONE];

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_OVR_HOLD: assert property (
        s_q.overrun_error && rx_on |=> s_q.overrun_error)
        else $error("overrun dropped while reception enabled");
    AST_OVR_CLEAR: assert property (
        !s_q.rcv_ctl[RC_CONTINUOUS_RECEIVE_ENABLE] |=> !s_q.overrun_error)
        else $error("overrun kept after receive enable cleared");
    AST_OVR_SET: assert property (
        done && !fifo_in_ready |=> s_q.overrun_error
        && s_q.int_stat[IS_OVERRUN])
        else $error("full fifo completion did not flag overrun");
    AST_PUSH: assert property (
        done && fifo_in_ready |=> fifo_valid)
        else $error("completed word not in holding fifo");
    AST_DONE_IRQ: assert property (
        done && s_q.int_mask[IS_WORD_DONE] |=> irq && $past(s_q.cnt) ==
        last_bit)
        else $error("completion did not raise interrupt");
    AST_WAKE: assert property (
        done && sleep_mode && s_q.int_mask[IS_WORD_DONE] |=>
        wake_request || !sleep_mode)
        else $error("completion in sleep did not wake");
    AST_DISABLE: assert property (
        !active |=> s_q.cnt == 4'd0 && !fifo_valid)
        else $error("disabled port not reset");
    AST_LEN: assert property (
        rx_on && clk_edge && s_q.cnt == 4'd7
        && s_q.rcv_ctl[RC_NINTH_BIT_RECEIVE_ENABLE] |=> s_q.cnt == 4'd8)
        else $error("ninth bit mode ended at eight bits");
    AST_BHOLD: assert property (
        s_q.bvalid && !s_axi_bready |=> s_q.bvalid && $stable(s_q.bresp))
        else $error("write response withdrawn early");
endmodule
`default_nettype wire

// *** dv/ssr_master_model.sv ***
// behavioural synchronous master that drives the shift clock and data
// pins of the receiver. assumes the bench starts one frame at a time.
`timescale 1ns/10ps
`default_nettype none
module ssr_master_model import ssr_pkg::*; (
    input wire logic aclk,
    input wire logic start,
    input wire logic [3:0] nbits,
    input wire logic [8:0] word,
    input wire logic [2:0] half,
    output logic busy,
    output logic sck,
    output logic sdo
);
    ////////////////////////////////////////////////////////////////////
    // clock stands high between frames; one process drives all outputs
    // one frame, lsb first; data set half a period before each fall
    initial begin
        busy = 1'h0;
        sck = 1'h1;
        sdo = 1'h0;
        forever begin
            @(posedge aclk);
            if (start && !busy) begin
                busy <= 1'h1;
                for (int i = 0; i < nbits; i++) begin
                    sdo <= word[i];
                    repeat (half) @(posedge aclk);
                    sck <= 1'h0;
                    repeat (half) @(posedge aclk);
                    sck <= 1'h1;
                end
                repeat (half) @(posedge aclk);
                sdo <= ~sdo; // data no longer valid after the frame
                busy <= 1'h0;
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench of the serial slave receiver: registers,
// framing, overrun, sleep wake-up and the enable gating.
// assumes the package, the design and the master model compile first.
`timescale 1ns/10ps
`default_nettype none
module tb import ssr_pkg::*;;
    localparam logic [7:0] A_RC = OFF_RECEIVE_STATUS_CONTROL_1;
    localparam logic [7:0] A_TX = OFF_TRANSMIT_STATUS_CONTROL_1;
    localparam logic [7:0] A_BD = OFF_BAUD_CONTROL_1;
    localparam logic [7:0] A_HOLD = OFF_RECEIVE_HOLDING_1;
    localparam logic [7:0] A_IST = OFF_INT_STATUS;
    localparam logic [7:0] A_IM = OFF_INT_MASK;
    localparam int DEPTH = 2;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h0;
    logic [7:0] araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, rd_v;
    logic [1:0] bresp, rresp, resp_v;
    logic sck, sdo, busy, ck_oe_n, d_oe_n, wake, irq, ck_o, d_o;
    logic sleep = 1'h0;
    logic st = 1'h0;
    logic [8:0] word = 9'h0;
    logic [3:0] nb = 4'h8;
    logic [2:0] half = 3'h3;
    int compares = 0;
    int miscompares = 0;

    ////////////////////////////////////////////////////////////////////
    // clock, design and far-side master
    always #25 aclk = ~aclk;

    ssr_receiver #(.ADDR_W(8), .FIFO_DEPTH(DEPTH)) dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp),
        .serial_clock_pin_in(sck),
        .serial_clock_pin_out(ck_o), .serial_clock_pin_oe_n(ck_oe_n),
        .serial_data_pin_in(sdo),
        .serial_data_pin_out(d_o), .serial_data_pin_oe_n(d_oe_n),
        .sleep_mode(sleep), .wake_request(wake), .irq(irq)
    );

    ssr_master_model mst_u (.aclk(aclk), .start(st), .nbits(nb),
        .word(word), .half(half), .busy(busy), .sck(sck), .sdo(sdo));

    ////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    // write address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        awaddr <= a;
        wdata <= {24'h0, d};
        bready <= 1'h1;
        do @(posedge aclk); while (awready !== 1'h1);
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        while (bvalid !== 1'h1) @(posedge aclk);
        resp_v = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        while (rvalid !== 1'h1) @(posedge aclk);
        rd_v = rdata;
        resp_v = rresp;
        rready <= 1'h0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rd_v, e);
    endtask

    task automatic cfg(input logic [7:0] tx, input logic [7:0] r);
        wr(A_TX, tx);
        wr(A_RC, r);
    endtask

    // one frame from the master, then let the word settle
    task automatic send(input logic [8:0] w, input logic [3:0] n);
        @(posedge aclk);
        word <= w;
        nb <= n;
        st <= 1'h1;
        @(posedge aclk);
        st <= 1'h0;
        repeat (2) @(posedge aclk);
        while (busy) @(posedge aclk);
        repeat (6) @(posedge aclk);
    endtask

    ////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs;
        rc(A_RC, 32'h0);
        rc(A_TX, 32'h2);
        rc(A_BD, 32'h40);
        wr(OFF_BAUD_DIVISOR_LOW_1, 8'h5c);
        wr(OFF_BAUD_DIVISOR_HIGH_1, 8'ha3);
        rc(OFF_BAUD_DIVISOR_LOW_1, 32'h5c);
        rc(OFF_BAUD_DIVISOR_HIGH_1, 32'ha3);
        wr(A_RC, 8'hff);
        rc(A_RC, 32'hf8);
        wr(A_RC, 8'h00);
        rd(8'h20);
        chk(rd_v, 32'h0);
        chk({30'h0, resp_v}, {30'h0, RESP_SLVERR});
        wr(8'h24, 8'h11);
        chk({30'h0, resp_v}, {30'h0, RESP_SLVERR});
        chk({30'h0, ck_oe_n, d_oe_n}, 32'h3);
        chk({30'h0, ck_o, d_o}, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_rx8;
        half = 3'h3;
        wr(A_IM, 8'h01);
        cfg(8'h10, 8'h90);
        rc(A_BD, 32'h0);
        send(9'h0a5, 4'h8);
        chk({31'h0, irq}, 32'h1);
        rc(A_IST, 32'h5);
        rc(A_HOLD, 32'ha5);
        rc(A_IST, 32'h1);
        wr(A_IM, 8'h00);
        chk({31'h0, irq}, 32'h0);
        wr(A_IM, 8'h01);
        wr(A_IST, 8'h01);
        chk({31'h0, irq}, 32'h0);
        // inverted data polarity: every synchronised bit flips
        wr(A_BD, 8'h20);
        send(9'h0a5, 4'h8);
        rc(A_HOLD, 32'h5a);
        wr(A_BD, 8'h00);
        wr(A_IST, 8'h01);
        $display("test rx8 done");
    endtask

    task automatic t_rx9;
        half = 3'h6;
        cfg(8'h10, 8'hf0);
        send(9'h13c, 4'h9);
        rc(A_RC, 32'hf1);
        rc(A_HOLD, 32'h3c);
        send(9'h0c3, 4'h9);
        rc(A_RC, 32'hf0);
        rc(A_HOLD, 32'hc3);
        wr(A_IST, 8'h03);
        $display("test rx9 done");
    endtask

    // fill past depth, then clear by receive enable alone and by clearing port and receive enable together
    task automatic t_ovr;
        half = 3'h3;
        wr(A_IM, 8'h02);
        for (int k = 0; k < 2; k++) begin
            cfg(8'h10, 8'h90);
            for (int i = 1; i <= DEPTH + 1; i++) send(9'(i * 17), 4'h8);
            chk({31'h0, irq}, 32'h1);
            rc(A_RC, 32'h92);
            rc(A_HOLD, 32'h11);
            rc(A_HOLD, 32'h22);
            rc(A_IST, 32'h3);
            rc(A_RC, 32'h92);
            wr(A_RC, (k == 0) ? 8'h80 : 8'h00);
            rc(A_RC, (k == 0) ? 32'h80 : 32'h0);
            wr(A_IST, 8'h03);
        end
        $display("test overrun done");
    endtask

    task automatic t_sleep;
        wr(A_IM, 8'h01);
        cfg(8'h10, 8'h90);
        sleep <= 1'h1;
        send(9'h069, 4'h8);
        chk({31'h0, wake}, 32'h1);
        rc(A_HOLD, 32'h69);
        sleep <= 1'h0;
        @(posedge aclk);
        chk({31'h0, wake}, 32'h0);
        wr(A_IST, 8'h03);
        $display("test sleep done");
    endtask

    // one configuration per gating term of rx_on that must keep the receiver off
    task automatic t_gate;
        logic [15:0] tbl [4] = '{16'h1010, 16'h9090, 16'h0090, 16'h1080};
        for (int i = 0; i < 4; i++) begin
            cfg(tbl[i][15:8], tbl[i][7:0]);
            send(9'h05a, 4'h8);
            rc(A_IST, 32'h0);
            rc(A_BD, 32'h40);
        end
        $display("test gating done");
    endtask

    ////////////////////////////////////////////////////////////////////
    // verdict, main sequence and watchdog
    task automatic print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs;
        t_rx8;
        t_rx9;
        t_ovr;
        t_sleep;
        t_gate;
        print_verdict;
    end

    initial begin
        repeat (40000) @(posedge aclk);
        miscompares++;
        print_verdict;
    end
endmodule
`default_nettype wire
